// >>> logic/pin_cfg_block.sv
// Pin configuration register, APB slave and per-pin event output
// Summary of operation
// - Channel select bit picks event A or B
// - Active level bit sets irq and event level
// - Pin held at active level for IRQ_MIN cycles sets interrupt flag
// - Routed event driven at chosen active level
// - Active level also sets timer clear level
// - Zero triggers low level, one triggers high
// - Event output enable bit allows event output
// - Event output enable forces pin to output
// - Event output keeps selected driver type
// - Driver type: zero open-drain, one push/pull
// - Open-drain drives only while its output value (data, or routed event at its level) is zero
// - Open-drain event, polarity zero idle: undriven
// - Direction bit: zero input, one output
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "pin_cfg_regs.svh"
module pin_cfg_block #(
  parameter int NUM_PINS = 3,
  parameter int IRQ_MIN  = `IRQ_MIN_CYCLES
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Data and direction register bits
  input  wire pin_cfg_pkg::pin_vec_t pin_direction,
  input  wire pin_cfg_pkg::pin_vec_t pin_data,
  // Time unit event channels
  input  wire logic                  evt_a,
  input  wire logic                  evt_b,
  // Pins
  input  wire pin_cfg_pkg::pin_vec_t pin_in,
  output pin_cfg_pkg::pin_vec_t      pin_out,
  output pin_cfg_pkg::pin_vec_t      pin_oe_n,
  // Status towards other blocks
  output pin_cfg_pkg::pin_vec_t      pin_irq_set,
  output pin_cfg_pkg::pin_vec_t      timer_clear_hit,
  output pin_cfg_pkg::pin_vec_t      pin_is_output,
  output pin_cfg_pkg::pin_vec_t      pin_read_value
);
  import pin_cfg_pkg::*;

  generate
    if (NUM_PINS != 3) begin : g_bad_pins
      $error("NUM_PINS must be 3 to match the register layout");
    end
    if (IRQ_MIN < 1) begin : g_bad_min
      $error("IRQ_MIN must be at least one cycle");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic        setup_ph;
  logic        access_ph;
  logic        hit_cfg;
  logic        hit_status;
  logic        addr_ok;
  logic [31:0] wmask;

  always_comb begin
    setup_ph   = psel && !penable;
    access_ph  = psel && penable;
    hit_cfg    = (paddr == `PIN_CFG_OFFSET);
    hit_status = (paddr == `PIN_STATUS_OFFSET);
    addr_ok    = hit_cfg || hit_status;
    wmask      = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  assign pready  = 1'b1;
  assign pslverr = access_ph && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  logic [31:0] cfg_reg, cfg_next;

  always_comb begin
    cfg_next = cfg_reg;
    if (access_ph && pwrite && hit_cfg) begin
      cfg_next = ((cfg_reg & ~wmask) | (pwdata & wmask)) & `PIN_CFG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `PIN_CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  pin_vec_t driver_type_select;
  pin_vec_t event_output_enable;
  pin_vec_t pin_active_level;
  pin_vec_t event_channel_select;

  assign driver_type_select   = cfg_reg[`BUF_LSB +: 3];
  assign event_output_enable  = cfg_reg[`EVT_OE_LSB +: 3];
  assign pin_active_level     = cfg_reg[`POL_LSB +: 3];
  assign event_channel_select = cfg_reg[`CHSEL_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Pin cells

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      pin_drive_cell #(
        .IRQ_MIN (IRQ_MIN)
      ) u_cell (
        .pclk                 (pclk),
        .presetn              (presetn),
        .driver_type_select   (drv_t'(driver_type_select[gi])),
        .event_output_enable  (event_output_enable[gi]),
        .pin_active_level     (pin_active_level[gi]),
        .event_channel_select (chan_t'(event_channel_select[gi])),
        .pin_direction        (pin_direction[gi]),
        .data_bit             (pin_data[gi]),
        .evt_a                (evt_a),
        .evt_b                (evt_b),
        .pin_in               (pin_in[gi]),
        .pin_out              (pin_out[gi]),
        .pin_oe_n             (pin_oe_n[gi]),
        .irq_hit              (pin_irq_set[gi]),
        .tclr_hit             (timer_clear_hit[gi]),
        .is_output            (pin_is_output[gi]),
        .read_value           (pin_read_value[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] prdata_reg, prdata_next;
  logic [31:0] status_word;

  always_comb begin
    status_word                     = 32'h0000_0000;
    status_word[`ST_RDVAL_LSB +: 3] = pin_read_value;
    status_word[`ST_ISOUT_LSB +: 3] = pin_is_output;
    status_word[`ST_IRQ_LSB +: 3]   = pin_irq_set;
    status_word[`ST_TCLR_LSB +: 3]  = timer_clear_hit;
    prdata_next = prdata_reg;
    if (setup_ph && !pwrite) begin
      if (hit_cfg) begin
        prdata_next = cfg_reg & `PIN_CFG_MASK;
      end else if (hit_status) begin
        prdata_next = status_word;
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on pin 0 and on the APB register port

  logic hit0;
  logic evt_sel0;

  assign hit0     = (pin_in[0] == pin_active_level[0]);
  assign evt_sel0 = event_channel_select[0] ? evt_b : evt_a;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_chan_a_route: assert property (
    (event_output_enable[0] && driver_type_select[0] && !event_channel_select[0])
    |=> pin_out[0] == ($past(evt_a) ~^ $past(pin_active_level[0])))
    else $error("pin 0 does not follow channel A");

  chk_chan_b_route: assert property (
    (event_output_enable[0] && driver_type_select[0] && event_channel_select[0])
    |=> pin_out[0] == ($past(evt_b) ~^ $past(pin_active_level[0])))
    else $error("pin 0 does not follow channel B at its level");

  chk_irq_level_set: assert property (
    hit0 [*2] |=> pin_irq_set[0])
    else $error("held active level did not set the flag");

  chk_irq_short_reject: assert property (
    $rose(pin_irq_set[0]) |-> $past(hit0) && $past(hit0, 2))
    else $error("flag set by a level shorter than two cycles");

  chk_irq_low_trig: assert property (
    (!pin_active_level[0] && pin_in[0]) |=> !pin_irq_set[0])
    else $error("high pin flagged with low trigger");

  chk_tclr_level: assert property (
    ##1 timer_clear_hit[0] == ($past(pin_in[0]) ~^ $past(pin_active_level[0])))
    else $error("timer clear level wrong");

  chk_event_forces_out: assert property (
    (event_output_enable[0] && driver_type_select[0] && !pin_direction[0])
    |=> !pin_oe_n[0] && pin_is_output[0])
    else $error("event output did not force output drive");

  chk_od_never_high: assert property (
    !driver_type_select[0] |=> !pin_out[0])
    else $error("open-drain pin driven high");

  chk_od_data_drive: assert property (
    (!driver_type_select[0] && !event_output_enable[0] && pin_direction[0])
    |=> pin_oe_n[0] == $past(pin_data[0]))
    else $error("open-drain drive does not follow data");

  chk_od_event_idle: assert property (
    (!driver_type_select[0] && event_output_enable[0] && !pin_active_level[0]
     && !evt_sel0) |=> pin_oe_n[0])
    else $error("open-drain idle event pin is driven");

  chk_input_float: assert property (
    (!event_output_enable[0] && !pin_direction[0]) |=> pin_oe_n[0] && !pin_is_output[0])
    else $error("input pin is driven");

  chk_cfg_write: assert property (
    (access_ph && pwrite && hit_cfg && pstrb[1])
    |=> cfg_reg[`EVT_OE_LSB +: 3] == $past(pwdata[`EVT_OE_LSB +: 3]))
    else $error("enable field write lost");

  chk_reserved_zero: assert property (
    (access_ph && hit_cfg && !pwrite) |-> (prdata & ~`PIN_CFG_MASK) == 32'h0000_0000)
    else $error("reserved bits read non-zero");

  chk_pp_data_drive: assert property (
    (driver_type_select[0] && !event_output_enable[0] && pin_direction[0])
    |=> !pin_oe_n[0] && pin_out[0] == $past(pin_data[0]))
    else $error("push/pull pin does not drive its data");

  chk_event_active_lvl: assert property (
    (event_output_enable[0] && driver_type_select[0] && evt_sel0)
    |=> pin_out[0] == $past(pin_active_level[0]))
    else $error("event not driven at the active level");

  chk_irq_high_trig: assert property (
    (pin_active_level[0] && !pin_in[0])
    |=> !pin_irq_set[0])
    else $error("low pin flagged with high trigger");

  chk_irq_level_drop: assert property (
    !hit0
    |=> !pin_irq_set[0])
    else $error("flag stayed up after the level left");

  chk_read_input: assert property (
    (!event_output_enable[0] && !pin_direction[0])
    |=> pin_read_value[0] == $past(pin_in[0]))
    else $error("input pin read value wrong");

  chk_read_output: assert property (
    (event_output_enable[0] || pin_direction[0])
    |=> pin_read_value[0] == $past(pin_data[0]))
    else $error("output pin read value wrong");

  chk_status_irq: assert property (
    (setup_ph && !pwrite && hit_status)
    |=> prdata[`ST_IRQ_LSB +: 3] == $past(pin_irq_set))
    else $error("status read lost the flag bits");

  chk_cfg_hold: assert property (
    !(access_ph && pwrite && hit_cfg)
    |=> $stable(cfg_reg))
    else $error("configuration changed without a write");

  chk_reserved_clear: assert property (
    presetn
    |-> (cfg_reg & ~`PIN_CFG_MASK) == 32'h0000_0000)
    else $error("reserved configuration bits set");

  cov_event_out: cover property (
    event_output_enable[0] ##1 $rose(pin_out[0]));
  cov_irq_set: cover property (
    $rose(pin_irq_set[0]));
  cov_cfg_write: cover property (
    access_ph && pwrite && hit_cfg);
  cov_bad_addr: cover property (
    pslverr);
  cov_od_event: cover property (
    !driver_type_select[0] && event_output_enable[0] && evt_sel0);
endmodule

// >>> logic/pin_drive_cell.sv
// One pin: driver, event routing, level detect and read value
`timescale 1ns/100ps
`include "pin_cfg_regs.svh"
module pin_drive_cell #(
  parameter int IRQ_MIN = `IRQ_MIN_CYCLES
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Configuration
  input  wire pin_cfg_pkg::drv_t    driver_type_select,
  input  wire logic                 event_output_enable,
  input  wire logic                 pin_active_level,
  input  wire pin_cfg_pkg::chan_t   event_channel_select,
  input  wire logic                 pin_direction,
  input  wire logic                 data_bit,
  // Events and pin
  input  wire logic                 evt_a,
  input  wire logic                 evt_b,
  input  wire logic                 pin_in,
  output logic                      pin_out,
  output logic                      pin_oe_n,
  // Results
  output logic                      irq_hit,
  output logic                      tclr_hit,
  output logic                      is_output,
  output logic                      read_value
);
  import pin_cfg_pkg::*;

  localparam int CNT_W = $clog2(IRQ_MIN + 1);

  generate
    if (IRQ_MIN < 1) begin : g_bad_min
      $error("IRQ_MIN must be at least one cycle");
    end
  endgenerate

  logic             out_reg,  out_next;
  logic             oe_n_reg, oe_n_next;
  logic             irq_reg,  irq_next;
  logic             tclr_reg, tclr_next;
  logic             dir_reg,  dir_next;
  logic             rd_reg,   rd_next;
  logic [CNT_W-1:0] cnt_reg,  cnt_next;
  logic             evt_sel;
  logic             drive_val;
  logic             hit;

  always_comb begin
    evt_sel   = (event_channel_select == CHAN_B) ? evt_b : evt_a;
    drive_val = event_output_enable ? (evt_sel ~^ pin_active_level) : data_bit;
    dir_next  = event_output_enable | pin_direction;
    hit       = (pin_in == pin_active_level);
    out_next  = 1'b0;
    oe_n_next = 1'b1;
    if (dir_next) begin
      if (driver_type_select == DRV_PUSH_PULL) begin
        out_next  = drive_val;
        oe_n_next = 1'b0;
      end else begin
        oe_n_next = drive_val;
      end
    end
    cnt_next  = hit ? ((cnt_reg == CNT_W'(IRQ_MIN)) ? cnt_reg : cnt_reg + 1'b1) : '0;
    irq_next  = hit && (cnt_reg >= CNT_W'(IRQ_MIN - 1));
    tclr_next = hit;
    rd_next   = dir_next ? data_bit : pin_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
      irq_reg  <= 1'b0;
      tclr_reg <= 1'b0;
      dir_reg  <= 1'b0;
      rd_reg   <= 1'b0;
      cnt_reg  <= '0;
    end else begin
      out_reg  <= out_next;
      oe_n_reg <= oe_n_next;
      irq_reg  <= irq_next;
      tclr_reg <= tclr_next;
      dir_reg  <= dir_next;
      rd_reg   <= rd_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign pin_out    = out_reg;
  assign pin_oe_n   = oe_n_reg;
  assign irq_hit    = irq_reg;
  assign tclr_hit   = tclr_reg;
  assign is_output  = dir_reg;
  assign read_value = rd_reg;
endmodule

// >>> shared/pin_cfg_pkg.sv
// Types shared by the pin configuration logic
package pin_cfg_pkg;
  typedef enum logic {CHAN_A, CHAN_B}                chan_t;
  typedef enum logic {DRV_OPEN_DRAIN, DRV_PUSH_PULL} drv_t;
  typedef logic [2:0]                                pin_vec_t;
endpackage

// >>> shared/pin_cfg_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PIN_CFG_REGS_SVH
`define PIN_CFG_REGS_SVH

`define PIN_CFG_OFFSET    12'h1e0
`define PIN_STATUS_OFFSET 12'h1f0
`define PIN_CFG_RESET     32'h0000_0000
`define PIN_CFG_MASK      32'h0707_0707
`define BUF_LSB           0
`define EVT_OE_LSB        8
`define POL_LSB           16
`define CHSEL_LSB         24
`define ST_RDVAL_LSB      0
`define ST_ISOUT_LSB      8
`define ST_IRQ_LSB        16
`define ST_TCLR_LSB       24
`define CLK_PERIOD_NS     20
`define IRQ_MIN_NS        40
`define IRQ_MIN_CYCLES    (((`IRQ_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

// >>> tb/pin_cfg_block_tb.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/100ps
`include "pin_cfg_regs.svh"
module pin_cfg_block_tb;
  import pin_cfg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, evt_a, evt_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  pin_vec_t    pin_direction, pin_data, pin_in, pin_out, pin_oe_n, ext_en, ext_val;
  pin_vec_t    pin_irq_set, timer_clear_hit, pin_is_output, pin_read_value;
  int          n_mismatch, checks_done, seed;
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  pin_cfg_block #(.NUM_PINS(3), .IRQ_MIN(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_direction(pin_direction), .pin_data(pin_data),
    .evt_a(evt_a), .evt_b(evt_b), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_irq_set(pin_irq_set), .timer_clear_hit(timer_clear_hit),
    .pin_is_output(pin_is_output), .pin_read_value(pin_read_value));
  pin_circuit_model i_pins (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(pin_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic err);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      print_verdict();
    end else begin
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // Returns {oe_n, out} for one pin
  function automatic logic [1:0] exp_drive(input logic [31:0] c, input logic dir,
                                           input logic d, input logic ea, input logic eb,
                                           input int i);
    logic v;
    if (!(c[8+i] | dir))
      return 2'b10;
    v = c[8+i] ? ((c[24+i] ? eb : ea) ~^ c[16+i]) : d;
    return c[i] ? {1'b0, v} : {v, 1'b0};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] cfg, rd, st;
    logic        err, ea, eb, outp, lvl;
    logic [1:0]  drv;
    pin_vec_t    dir, data, ev;
    seed = 32'hcdd3;
    {presetn, psel, penable, pwrite, evt_a, evt_b} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    {pin_direction, pin_data, ext_en, ext_val} = 12'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PIN_CFG_OFFSET, 32'h0, 4'hf, rd, err);
    check("cfg reset", rd, 32'h0);
    apb(1'b1, `PIN_CFG_OFFSET, 32'hffffffff, 4'h1, rd, err);
    apb(1'b0, `PIN_CFG_OFFSET, 32'h0, 4'hf, rd, err);
    check("cfg lane0", rd, 32'h7);
    apb(1'b1, `PIN_CFG_OFFSET, 32'hffffffff, 4'hf, rd, err);
    apb(1'b0, `PIN_CFG_OFFSET, 32'h0, 4'hf, rd, err);
    check("cfg reserved", rd, 32'h07070707);
    apb(1'b1, `PIN_STATUS_OFFSET, 32'h0, 4'hf, rd, err);
    check("status write err", err, 1'b0);
    apb(1'b1, 12'h1fc, 32'h0, 4'hf, rd, err);
    check("unmapped write err", err, 1'b1);
    apb(1'b0, `PIN_CFG_OFFSET, 32'h0, 4'hf, rd, err);
    check("cfg after stray writes", rd, 32'h07070707);
    apb(1'b0, 12'h1fc, 32'h0, 4'hf, rd, err);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    for (int k = 0; k < 48; k++) begin
      cfg = $random(seed) & `PIN_CFG_MASK;
      {ev, data, dir} = 9'($random(seed));
      {ea, eb} = 2'($random(seed));
      if (k == 0) begin
        cfg = 32'h0;
        data = 3'h7;
        dir = 3'h7;
      end
      if (k == 1) begin
        cfg = 32'h00000700;
        ea = 1'b0;
      end
      ext_en <= 3'h0;
      apb(1'b1, `PIN_CFG_OFFSET, cfg, 4'hf, rd, err);
      pin_direction <= dir;
      pin_data <= data;
      evt_a <= ea;
      evt_b <= eb;
      repeat (2) @(posedge pclk);
      ext_en <= ~(dir | cfg[10:8]);
      ext_val <= ev;
      repeat (6) @(posedge pclk);
      st = 32'h0;
      for (int i = 0; i < 3; i++) begin
        drv = exp_drive(cfg, dir[i], data[i], ea, eb, i);
        outp = cfg[8+i] | dir[i];
        lvl = !drv[1] ? drv[0] : (outp ? 1'b1 : ev[i]);
        check("pin_oe_n", pin_oe_n[i], drv[1]);
        check("pin_out", pin_out[i], drv[0]);
        check("pin_is_output", pin_is_output[i], outp);
        check("pin_irq_set", pin_irq_set[i], lvl == cfg[16+i]);
        check("timer_clear_hit", timer_clear_hit[i], lvl == cfg[16+i]);
        check("pin_read_value", pin_read_value[i], outp ? data[i] : lvl);
        st[`ST_RDVAL_LSB+i] = outp ? data[i] : lvl;
        st[`ST_ISOUT_LSB+i] = outp;
        st[`ST_IRQ_LSB+i]   = (lvl == cfg[16+i]);
        st[`ST_TCLR_LSB+i]  = (lvl == cfg[16+i]);
      end
      apb(1'b0, `PIN_STATUS_OFFSET, 32'h0, 4'hf, rd, err);
      check("pin status", rd, st);
    end
    ext_en <= 3'h0;
    apb(1'b1, `PIN_CFG_OFFSET, 32'h0, 4'hf, rd, err);
    pin_direction <= 3'h0;
    repeat (2) @(posedge pclk);
    ext_en <= 3'h7;
    ext_val <= 3'h7;
    repeat (6) @(posedge pclk);
    ext_val <= 3'h6;
    @(posedge pclk);
    ext_val <= 3'h7;
    repeat (4) begin
      @(negedge pclk);
      check("irq short pulse", pin_irq_set, 3'h0);
    end
    @(posedge pclk);
    ext_val <= 3'h6;
    repeat (2) @(posedge pclk);
    ext_val <= 3'h7;
    @(negedge pclk);
    check("irq two samples", pin_irq_set, 3'h1);
    print_verdict();
  end
endmodule

// >>> tb/pin_circuit_model.sv
// External circuitry on the three pins: pull-ups and an optional driver
`timescale 1ns/100ps
module pin_circuit_model (
  // Design side
  input  wire pin_cfg_pkg::pin_vec_t pin_out,
  input  wire pin_cfg_pkg::pin_vec_t pin_oe_n,
  // Stimulus side
  input  wire pin_cfg_pkg::pin_vec_t ext_en,
  input  wire pin_cfg_pkg::pin_vec_t ext_val,
  // Resolved levels
  output pin_cfg_pkg::pin_vec_t      pin_level
);
  import pin_cfg_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!pin_oe_n[i] && ext_en[i]) begin
        pin_level[i] = 1'bx;
      end else if (!pin_oe_n[i]) begin
        pin_level[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule
